//--- verilog/vel_mon_pkg.sv
// Constants and types for the velocity-mode supervision block
// Operation
// RULE_01 - The speed flag drops to 0 once speed stays above the threshold for the threshold time.
// RULE_02 - The speed flag rises to 1 at once when actual speed falls below the threshold.
// RULE_03 - Threshold and threshold time are unsigned 16-bit values, the time in whole milliseconds.
// RULE_04 - The commanded velocity is the target velocity plus the velocity offset.
// RULE_05 - That sum is clamped by the least of max profile speed, max motor speed and 2147483647.
// RULE_06 - Both speed limits are captured at motion start and later writes wait for the next one.
// RULE_07 - The host waits at least 100 ms after enabling operation before sending speed commands.
// RULE_08 - The reached flag clears whenever the speed deviation leaves the window.
// RULE_09 - The reached flag sets only after the deviation stays in the window for the window time.
// RULE_10 - The reached flag may toggle when the deviation wanders about the window edge.
// RULE_11 - In cyclic mode a new command arrives every interpolation cycle under synchronised timing.
// RULE_12 - Torque limits and max torque are unsigned 16-bit values in tenths of a percent.
// RULE_13 - Under halt the reached flag means axis stopped, otherwise speed control completed; the code never reads the halt bit.
// RULE_14 - Each millisecond qualifier restarts from zero whenever its condition lapses.
package vel_mon_pkg;
	// Object indices
	localparam logic [15:0] IDX_EXT_SETUP3  = 16'h3724;
	localparam logic [15:0] IDX_LOOP_TQ_LIM = 16'h4312;
	localparam logic [15:0] IDX_CTRL_WORD   = 16'h6040;
	localparam logic [15:0] IDX_STATUS_WORD = 16'h6041;
	localparam logic [15:0] IDX_THRESH      = 16'h606F;
	localparam logic [15:0] IDX_THRESH_TIME = 16'h6070;
	localparam logic [15:0] IDX_WINDOW      = 16'h606D;
	localparam logic [15:0] IDX_WIN_TIME    = 16'h606E;
	localparam logic [15:0] IDX_TQ_CEIL     = 16'h6072;
	localparam logic [15:0] IDX_MAX_PROF    = 16'h607F;
	localparam logic [15:0] IDX_MOTOR_CEIL  = 16'h6080;
	localparam logic [15:0] IDX_VEL_OFFSET  = 16'h60B1;
	localparam logic [15:0] IDX_TQ_OFFSET   = 16'h60B2;
	localparam logic [15:0] IDX_FWD_TQ_LIM  = 16'h60E0;
	localparam logic [15:0] IDX_REV_TQ_LIM  = 16'h60E1;
	localparam logic [15:0] IDX_TARGET      = 16'h60FF;
	// Field positions
	localparam int BIT_ENABLE_OP = 3;
	localparam int BIT_HALT      = 8;
	localparam int BIT_REACHED   = 10;
	localparam int BIT_STOPPED   = 12;
	// Reset values
	localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
	localparam logic [31:0] POS_LIMIT = 32'h7FFF_FFFF;
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	// Object access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] index;
		logic [31:0] wdata;
	} obj_req_s;
endpackage

//--- verilog/vel_mon.sv
// Velocity-mode command forming and speed / target-reached status
`timescale 1ns/10ps
`default_nettype none
module vel_mon #(
	parameter int MS_CYCLES = vel_mon_pkg::MS_CYCLES
) (
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	input  wire logic                  ce,
	input  wire vel_mon_pkg::obj_req_s req,
	input  wire logic signed [31:0]    vel_actual,
	output logic [31:0]                rdata_ff,
	output logic                       rvalid_ff,
	output logic                       rerr_ff,
	output logic signed [31:0]         vel_cmd_ff,
	output logic                       stopped_ff,
	output logic                       reached_ff
);
	// Object storage
	logic [15:0] ext_setup3_ff, loop_tq_ff, ctrl_ff, thresh_ff, thresh_time_ff;
	logic [15:0] window_ff, win_time_ff, tq_ceil_ff, tq_off_ff, fwd_tq_ff, rev_tq_ff;
	logic [31:0] max_prof_ff, motor_ceil_ff, vel_off_ff, target_ff;
	logic [31:0] lim_ff;
	logic        en_q_ff;
	logic [31:0] tick_cnt_ff;
	logic        tick_ff;
	logic [15:0] spd_cnt_ff, win_cnt_ff;
	logic        op_rise, above, below, inwin;
	logic signed [32:0] sum;
	logic signed [31:0] nxt_cmd;
	logic [32:0] dev_mag;
	logic        run_ok, win_ok;
	logic signed [32:0] lim_pos;

	// Magnitude of a signed 33-bit value
	function automatic logic [32:0] mag33(input logic signed [32:0] v);
		return v[32] ? 33'(-v) : 33'(v);
	endfunction

	// Smaller of two unsigned words
	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction

	// Clamp a signed sum to +/- limit
	function automatic logic signed [31:0] clamp(input logic signed [32:0] s,
			input logic [31:0] l);
		logic signed [32:0] hi;
		hi = $signed({1'b0, l});
		if (s > hi) begin
			return l;
		end else if (s < -hi) begin
			return 32'(-hi);
		end
		return s[31:0];
	endfunction

	// Start of motion on rising enable-operation
	assign op_rise = ctrl_ff[vel_mon_pkg::BIT_ENABLE_OP] & ~en_q_ff;
	// Sum, comparisons and deviation
	assign sum     = 33'($signed(target_ff)) + 33'($signed(vel_off_ff)); // RULE_04
	assign nxt_cmd = clamp(sum, lim_ff); // RULE_05
	assign above   = mag33(33'(vel_actual)) > {17'h0_0000, thresh_ff};
	assign below   = mag33(33'(vel_actual)) < {17'h0_0000, thresh_ff};
	assign dev_mag = mag33(33'(vel_cmd_ff) - 33'(vel_actual));
	assign inwin   = dev_mag <= {17'h0_0000, window_ff};
	// Qualified conditions and signed limit
	assign run_ok  = above && spd_cnt_ff >= thresh_time_ff;
	assign win_ok  = inwin && win_cnt_ff >= win_time_ff;
	assign lim_pos = $signed({1'b0, lim_ff});

	// Object writes; host may refresh commands every cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ext_setup3_ff  <= 16'h0000;
			loop_tq_ff     <= 16'h0000;
			ctrl_ff        <= 16'h0000;
			thresh_ff      <= 16'h0000;
			thresh_time_ff <= 16'h0000;
			window_ff      <= 16'h0000;
			win_time_ff    <= 16'h0000;
			tq_ceil_ff     <= 16'h0000;
			tq_off_ff      <= 16'h0000;
			fwd_tq_ff      <= 16'h0000;
			rev_tq_ff      <= 16'h0000;
			max_prof_ff    <= vel_mon_pkg::POS_LIMIT;
			motor_ceil_ff  <= vel_mon_pkg::POS_LIMIT;
			vel_off_ff     <= vel_mon_pkg::RST_ZERO;
			target_ff      <= vel_mon_pkg::RST_ZERO;
		end else if (ce && req.wr) begin
			case (req.index)
				vel_mon_pkg::IDX_EXT_SETUP3:  ext_setup3_ff  <= req.wdata[15:0];
				vel_mon_pkg::IDX_LOOP_TQ_LIM: loop_tq_ff     <= req.wdata[15:0]; // RULE_12
				vel_mon_pkg::IDX_CTRL_WORD:   ctrl_ff        <= req.wdata[15:0];
				vel_mon_pkg::IDX_THRESH:      thresh_ff      <= req.wdata[15:0]; // RULE_03
				vel_mon_pkg::IDX_THRESH_TIME: thresh_time_ff <= req.wdata[15:0]; // RULE_03
				vel_mon_pkg::IDX_WINDOW:      window_ff      <= req.wdata[15:0];
				vel_mon_pkg::IDX_WIN_TIME:    win_time_ff    <= req.wdata[15:0];
				vel_mon_pkg::IDX_TQ_CEIL:     tq_ceil_ff     <= req.wdata[15:0]; // RULE_12
				vel_mon_pkg::IDX_TQ_OFFSET:   tq_off_ff      <= req.wdata[15:0];
				vel_mon_pkg::IDX_FWD_TQ_LIM:  fwd_tq_ff      <= req.wdata[15:0]; // RULE_12
				vel_mon_pkg::IDX_REV_TQ_LIM:  rev_tq_ff      <= req.wdata[15:0]; // RULE_12
				vel_mon_pkg::IDX_MAX_PROF:    max_prof_ff    <= req.wdata;
				vel_mon_pkg::IDX_MOTOR_CEIL:  motor_ceil_ff  <= req.wdata;
				vel_mon_pkg::IDX_VEL_OFFSET:  vel_off_ff     <= req.wdata; // RULE_11
				vel_mon_pkg::IDX_TARGET:      target_ff      <= req.wdata; // RULE_11
				default: ;
			endcase
		end
	end

	// Object reads, one-cycle answer
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff  <= vel_mon_pkg::RST_ZERO;
			rvalid_ff <= 1'b0;
			rerr_ff   <= 1'b0;
		end else if (ce) begin
			rvalid_ff <= req.rd;
			rerr_ff   <= 1'b0;
			rdata_ff  <= vel_mon_pkg::RST_ZERO;
			if (req.rd) begin
				case (req.index)
					vel_mon_pkg::IDX_EXT_SETUP3:  rdata_ff <= {16'h0000, ext_setup3_ff};
					vel_mon_pkg::IDX_LOOP_TQ_LIM: rdata_ff <= {16'h0000, loop_tq_ff};
					vel_mon_pkg::IDX_CTRL_WORD:   rdata_ff <= {16'h0000, ctrl_ff};
					vel_mon_pkg::IDX_STATUS_WORD: begin
						rdata_ff[vel_mon_pkg::BIT_STOPPED] <= stopped_ff;
						rdata_ff[vel_mon_pkg::BIT_REACHED] <= reached_ff;
					end
					vel_mon_pkg::IDX_THRESH:      rdata_ff <= {16'h0000, thresh_ff};
					vel_mon_pkg::IDX_THRESH_TIME: rdata_ff <= {16'h0000, thresh_time_ff};
					vel_mon_pkg::IDX_WINDOW:      rdata_ff <= {16'h0000, window_ff};
					vel_mon_pkg::IDX_WIN_TIME:    rdata_ff <= {16'h0000, win_time_ff};
					vel_mon_pkg::IDX_TQ_CEIL:     rdata_ff <= {16'h0000, tq_ceil_ff};
					vel_mon_pkg::IDX_TQ_OFFSET:   rdata_ff <= {16'h0000, tq_off_ff};
					vel_mon_pkg::IDX_FWD_TQ_LIM:  rdata_ff <= {16'h0000, fwd_tq_ff};
					vel_mon_pkg::IDX_REV_TQ_LIM:  rdata_ff <= {16'h0000, rev_tq_ff};
					vel_mon_pkg::IDX_MAX_PROF:    rdata_ff <= max_prof_ff;
					vel_mon_pkg::IDX_MOTOR_CEIL:  rdata_ff <= motor_ceil_ff;
					vel_mon_pkg::IDX_VEL_OFFSET:  rdata_ff <= vel_off_ff;
					vel_mon_pkg::IDX_TARGET:      rdata_ff <= target_ff;
					default:                      rerr_ff  <= 1'b1;
				endcase
			end
		end
	end

	// Capture speed limits at motion start
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			en_q_ff <= 1'b0;
			lim_ff  <= vel_mon_pkg::RST_ZERO;
		end else if (ce) begin
			en_q_ff <= ctrl_ff[vel_mon_pkg::BIT_ENABLE_OP];
			if (op_rise) begin
				lim_ff <= umin(umin(max_prof_ff, motor_ceil_ff), vel_mon_pkg::POS_LIMIT); // RULE_06
			end
		end
	end

	// Commanded velocity, zero while operation is disabled
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			vel_cmd_ff <= 32'sh0000_0000;
		end else if (ce) begin
			vel_cmd_ff <= en_q_ff ? nxt_cmd : 32'sh0000_0000; // RULE_05
		end
	end

	// Millisecond tick
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_ff <= vel_mon_pkg::RST_ZERO;
			tick_ff     <= 1'b0;
		end else if (ce) begin
			tick_ff     <= (tick_cnt_ff == 32'(MS_CYCLES - 1));
			tick_cnt_ff <= (tick_cnt_ff == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt_ff + 32'h1;
		end
	end

	// Speed flag: immediate stop, qualified run
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			spd_cnt_ff <= 16'h0000;
			stopped_ff <= 1'b1;
		end else if (ce) begin
			if (!above) begin
				spd_cnt_ff <= 16'h0000; // RULE_14
			end else if (tick_ff && spd_cnt_ff != 16'hFFFF) begin
				spd_cnt_ff <= spd_cnt_ff + 16'h1;
			end
			if (below) begin
				stopped_ff <= 1'b1; // RULE_02
			end else if (above && spd_cnt_ff >= thresh_time_ff) begin
				stopped_ff <= 1'b0; // RULE_01
			end
		end
	end

	// Reached flag; halt bit is not read, flag always tracks the command deviation window
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			win_cnt_ff <= 16'h0000;
			reached_ff <= 1'b0;
		end else if (ce) begin
			if (!inwin) begin
				win_cnt_ff <= 16'h0000; // RULE_14
				reached_ff <= 1'b0; // RULE_08 RULE_10
			end else begin
				if (tick_ff && win_cnt_ff != 16'hFFFF) begin
					win_cnt_ff <= win_cnt_ff + 16'h1;
				end
				if (win_cnt_ff >= win_time_ff) begin
					reached_ff <= 1'b1; // RULE_09 RULE_13
				end
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_motion_start;
		ce && op_rise;
	endsequence
	sequence s_limit_hold;
		!(ce && op_rise) [*2];
	endsequence

	sequence s_read_req;
		ce && req.rd;
	endsequence
	sequence s_read_ans;
		rvalid_ff;
	endsequence

	// Speed flag
	a_stop_immediate: assert property (ce && below |=> stopped_ff) // RULE_02
		else $error("stop flag not set on low speed");
	a_run_after_time: assert property ($fell(stopped_ff) |-> $past(run_ok)) // RULE_01
		else $error("run flag without qualified time");
	a_run_qualify: assert property (ce && run_ok |=> !stopped_ff) // RULE_01
		else $error("qualified speed did not clear stop flag");
	a_stop_hold: assert property (ce && stopped_ff && !run_ok |=> stopped_ff) // RULE_01
		else $error("stop flag cleared without qualified time");
	a_timer_restart: assert property (ce && !above |=> spd_cnt_ff == 16'h0000) // RULE_14
		else $error("speed timer not restarted");
	a_spd_count: assert property (ce && above && tick_ff && spd_cnt_ff != 16'hFFFF |=> // RULE_01
		spd_cnt_ff == $past(spd_cnt_ff) + 16'h1)
		else $error("speed timer missed a tick");

	// Reached flag and millisecond tick
	a_reach_clear: assert property (ce && !inwin |=> !reached_ff) // RULE_08
		else $error("reached flag kept outside window");
	a_reach_qualify: assert property ($rose(reached_ff) |-> $past(win_ok)) // RULE_09
		else $error("reached flag set early");
	a_reach_set: assert property (ce && win_ok |=> reached_ff) // RULE_09
		else $error("reached flag not set after window time");
	a_win_restart: assert property (ce && !inwin |=> win_cnt_ff == 16'h0000) // RULE_14
		else $error("window timer not restarted");
	a_win_count: assert property (ce && inwin && tick_ff && win_cnt_ff != 16'hFFFF |=> // RULE_09
		win_cnt_ff == $past(win_cnt_ff) + 16'h1)
		else $error("window timer missed a tick");
	a_tick_pulse: assert property (ce && tick_ff |=> !tick_ff)
		else $error("millisecond tick longer than one cycle");

	// Command forming and limits
	a_cmd_clamped: assert property (ce && en_q_ff |=> // RULE_05
		33'(vel_cmd_ff) <= lim_pos && 33'(vel_cmd_ff) >= -lim_pos)
		else $error("command exceeds limit");
	a_cmd_disabled: assert property (ce && !en_q_ff |=> vel_cmd_ff == 32'sh0000_0000) // RULE_05
		else $error("command while operation disabled");
	a_limit_frozen: assert property (s_limit_hold |-> $stable(lim_ff)) // RULE_06
		else $error("limit changed mid motion");
	a_limit_capture: assert property (s_motion_start ##1 1'b1 |-> // RULE_06
		lim_ff <= $past(max_prof_ff) && lim_ff <= $past(motor_ceil_ff) &&
		lim_ff <= vel_mon_pkg::POS_LIMIT)
		else $error("captured limit above a ceiling");
	a_sum_pass: assert property (ce && en_q_ff && sum >= -lim_pos && sum <= lim_pos |=> // RULE_04
		33'(vel_cmd_ff) == $past(sum))
		else $error("command differs from sum");

	// Object port answers and clock enable
	a_read_answer: assert property (s_read_req |=> s_read_ans)
		else $error("read not answered next cycle");
	a_err_with_valid: assert property (rerr_ff |-> rvalid_ff)
		else $error("read error without valid");
	a_idle_no_valid: assert property (ce && !req.rd |=> !rvalid_ff && rdata_ff == 32'h0000_0000)
		else $error("read answer without request");
	a_status_bits: assert property (ce && req.rd && req.index == vel_mon_pkg::IDX_STATUS_WORD |=> // RULE_13
		rdata_ff[vel_mon_pkg::BIT_STOPPED] == $past(stopped_ff) &&
		rdata_ff[vel_mon_pkg::BIT_REACHED] == $past(reached_ff))
		else $error("status word bits differ from flags");
	a_ce_frozen: assert property (!ce |=>
		$stable(stopped_ff) && $stable(reached_ff) && $stable(vel_cmd_ff) && $stable(lim_ff))
		else $error("state moved while clock enable low");
endmodule
`default_nettype wire

//--- dv/fieldbus_host.sv
// Host controller model issuing object accesses to the drive
`timescale 1ns/10ps
`default_nettype none
module fieldbus_host #(
	parameter int MS = 10
) (
	input  wire logic                 ref_clk,
	output var  vel_mon_pkg::obj_req_s req,
	input  wire logic [31:0]          rdata_ff,
	input  wire logic                 rvalid_ff,
	input  wire logic                 rerr_ff
);
	// One-cycle strobe; released lines show inverted leftovers
	task automatic access(input logic w, input logic [15:0] i, input logic [31:0] v);
		@(posedge ref_clk);
		req <= '{wr: w, rd: !w, index: i, wdata: v};
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b0, index: ~i, wdata: ~v};
		#1;
	endtask
	// Read with a bounded wait for the answer
	task automatic rd(input logic [15:0] i, output logic [31:0] v, output logic e, output bit ok);
		access(1'b0, i, 32'h0000_0000);
		ok = 0;
		v = '0;
		e = 1'b0;
		for (int n = 0; n < 4 && !ok; n++) begin
			if (rvalid_ff === 1'b1) begin
				ok = 1;
				v = rdata_ff;
				e = rerr_ff;
			end else begin
				@(posedge ref_clk);
				#1;
			end
		end
	endtask
	// Enable operation; commands held off for 100 ms afterwards
	task automatic enable_op(input logic on);
		access(1'b1, vel_mon_pkg::IDX_CTRL_WORD, {28'h0, on, 3'h0});
		if (on) begin
			repeat (100 * MS) @(posedge ref_clk);
		end
		#1;
	endtask
	initial req = '0;
endmodule
`default_nettype wire

//--- dv/velocity_mode_status_monitor_bench.sv
// Self-checking bench for the velocity supervision block
`timescale 1ns/10ps
`default_nettype none
module velocity_mode_status_monitor_bench;
	localparam int MS = 10;
	logic                  ref_clk = 1'b0;
	logic                  nrst = 1'b0;
	logic                  ce = 1'b1;
	logic signed [31:0]    vel_actual = '0;
	vel_mon_pkg::obj_req_s req;
	logic [31:0]           rdata_ff, d, want, tgt, ofs;
	logic signed [31:0]    vel_cmd_ff;
	logic                  rvalid_ff, rerr_ff, stopped_ff, reached_ff, e;
	bit                    ok;
	int                    failures = 0;
	int                    checks = 0;
	logic [15:0]           idx [14] = '{16'h3724, 16'h4312, 16'h606F, 16'h6070, 16'h606D,
		16'h606E, 16'h6072, 16'h60B2, 16'h60E0, 16'h60E1, 16'h607F, 16'h6080, 16'h60B1, 16'h60FF};
	vel_mon #(.MS_CYCLES(MS)) uut (
		.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .req(req), .vel_actual(vel_actual),
		.rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .rerr_ff(rerr_ff),
		.vel_cmd_ff(vel_cmd_ff), .stopped_ff(stopped_ff), .reached_ff(reached_ff)
	);
	fieldbus_host #(.MS(MS)) host (
		.ref_clk(ref_clk), .req(req), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff),
		.rerr_ff(rerr_ff)
	);
	// Clock generation
	initial forever #4 ref_clk = ~ref_clk;
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp_v);
		checks++;
		if (seen !== exp_v) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp_v, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Read an object and compare with the expected value
	task automatic rchk(input string name, input logic [15:0] i, input logic [31:0] x);
		host.rd(i, d, e, ok);
		if (!ok) begin
			failures++;
			final_report();
		end else check(name, d, x);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic setv(input logic signed [31:0] v);
		@(posedge ref_clk);
		vel_actual <= v;
		#1;
	endtask
	function automatic logic [31:0] clampv(input logic [31:0] s, input logic [31:0] l);
		return ($signed(s) > $signed(l)) ? l : s;
	endfunction
	// Overall hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		final_report();
	end
	// Main sequence
	initial begin
		void'($urandom(72));
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		cyc(1);
		check("vel_cmd", vel_cmd_ff, 32'h0);
		check("stopped", 32'(stopped_ff), 32'h1);
		foreach (idx[k]) begin
			rchk("reset", idx[k], (k == 10 || k == 11) ? 32'h7FFF_FFFF : 32'h0);
			want = $urandom;
			host.access(1'b1, idx[k], want);
			if (k < 10) want[31:16] = 16'h0;
			rchk("readback", idx[k], want);
		end
		host.access(1'b1, 16'h6041, 32'h0000_FFFF);
		rchk("status", 16'h6041, 32'h0000_1400);
		rchk("unmapped", 16'h1234, 32'h0);
		check("rerr", 32'(e), 32'h1);
		host.access(1'b1, 16'h606F, 32'd100);
		host.access(1'b1, 16'h6070, 32'd3);
		host.access(1'b1, 16'h606D, 32'd50);
		host.access(1'b1, 16'h606E, 32'd2);
		host.access(1'b1, 16'h607F, 32'd1000);
		host.access(1'b1, 16'h6080, 32'd4000);
		host.access(1'b1, 16'h60FF, 32'd1200);
		host.access(1'b1, 16'h60B1, 32'd300);
		host.enable_op(1'b1);
		check("clamp", vel_cmd_ff, 32'd1000);
		host.access(1'b1, 16'h607F, 32'd500);
		cyc(4);
		check("latched", vel_cmd_ff, 32'd1000);
		repeat (4) begin
			tgt = $urandom_range(900);
			ofs = $urandom_range(400) - 200;
			host.access(1'b1, 16'h60FF, tgt);
			host.access(1'b1, 16'h60B1, ofs);
			cyc(3);
			check("sum", vel_cmd_ff, clampv(tgt + ofs, 32'd1000));
		end
		host.enable_op(1'b0);
		host.access(1'b1, 16'h60FF, 32'd900);
		host.access(1'b1, 16'h60B1, 32'h0);
		host.enable_op(1'b1);
		check("relatch", vel_cmd_ff, 32'd500);
		// Negative sum meets the mirrored limit
		host.access(1'b1, 16'h60FF, 32'hFFFF_F448);
		cyc(3);
		check("clamp_neg", vel_cmd_ff, 32'hFFFF_FE0C);
		host.access(1'b1, 16'h60FF, 32'd900);
		cyc(3);
		// Speed flag with an interrupted interval
		setv(200);
		cyc(2 * MS - 1);
		check("stopped", 32'(stopped_ff), 32'h1);
		setv(50);
		cyc(2);
		check("stopped", 32'(stopped_ff), 32'h1);
		setv(200);
		cyc(2 * MS - 1);
		check("stopped", 32'(stopped_ff), 32'h1);
		check("reached", 32'(reached_ff), 32'h0);
		cyc(MS + 5);
		check("stopped", 32'(stopped_ff), 32'h0);
		// Target-reached window
		setv(520);
		cyc(MS - 1);
		check("reached", 32'(reached_ff), 32'h0);
		cyc(MS + 6);
		check("reached", 32'(reached_ff), 32'h1);
		setv(600);
		cyc(2);
		check("reached", 32'(reached_ff), 32'h0);
		// Clock enable low freezes the flags
		@(posedge ref_clk);
		ce <= 1'b0;
		vel_actual <= 32'sd50;
		cyc(5);
		check("frozen", 32'(stopped_ff), 32'h0);
		@(posedge ref_clk);
		ce <= 1'b1;
		cyc(2);
		check("stopped", 32'(stopped_ff), 32'h1);
		final_report();
	end
endmodule
`default_nettype wire
